// ==== hw/vdrt_pkg.sv ====
package vdrt_pkg;
  localparam int ROW_W = 9;
  localparam int COL_W = 9;
  localparam int DATA_W = 4;
  localparam int TAP_LAST = 511;
  localparam logic [COL_W-1:0] TAP_RST = 9'h000;
  localparam logic [COL_W-1:0] TAP_STEP = 9'h001;
  typedef enum logic [1:0] {
    VDRT_XFER_NONE,
    VDRT_XFER_READ,
    VDRT_XFER_WRITE,
    VDRT_XFER_PSEUDO
  } vdrt_xfer_e;
  typedef enum logic {
    VDRT_MODE_INPUT,
    VDRT_MODE_OUTPUT
  } vdrt_mode_e;
endpackage : vdrt_pkg

// ==== hw/vdrt_tap_if.sv ====
`timescale 1ns/10ps
interface vdrt_tap_if;
  import vdrt_pkg::*;
  logic             loadTgl;
  logic [COL_W-1:0] loadCol;
  logic [COL_W-1:0] tapPtr; // Gray coded
  logic             tapValid;
  modport ctrl (output loadTgl, output loadCol,
                input tapPtr, input tapValid);
  modport tap  (input loadTgl, input loadCol,
                output tapPtr, output tapValid);
endinterface : vdrt_tap_if

// ==== hw/vdrt_tap_ptr.sv ====
`timescale 1ns/10ps
module vdrt_tap_ptr
  import vdrt_pkg::*;
(
  // Link clock
  input  wire logic shiftClock,
  input  wire logic rstn,
  // Control side
  vdrt_tap_if.tap   tapIf
);
  logic [2:0]       tglSync_q;
  logic [COL_W-1:0] ptr_q;
  logic             valid_q;
  logic             pend;
  logic [COL_W-1:0] ptr_d;
  logic [COL_W-1:0] gray_q;

  // Toggle crossing; column word is stable long before toggle arrives
  always_ff @(posedge shiftClock or negedge rstn) begin
    if (!rstn) begin
      tglSync_q <= 3'h0;
    end else begin
      tglSync_q <= {tglSync_q[1:0], tapIf.loadTgl};
    end
  end
  assign pend = tglSync_q[2] ^ tglSync_q[1];

  always_comb begin
    if (pend) begin
      ptr_d = tapIf.loadCol;
    end else if (ptr_q == COL_W'(TAP_LAST)) begin
      ptr_d = TAP_RST;
    end else begin
      ptr_d = ptr_q + TAP_STEP;
    end
  end

  // Gray copy so the control side never sees a torn step
  always_ff @(posedge shiftClock or negedge rstn) begin
    if (!rstn) begin
      ptr_q   <= TAP_RST;
      gray_q  <= TAP_RST;
      valid_q <= 1'b0;
    end else begin
      ptr_q   <= ptr_d;
      gray_q  <= ptr_d ^ (ptr_d >> 1);
      valid_q <= valid_q | pend;
    end
  end
  assign tapIf.tapPtr   = gray_q;
  assign tapIf.tapValid = valid_q;
endmodule : vdrt_tap_ptr

// ==== hw/vdrt_xfer_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// - Transfer: select low at row strobe fall
// - Read transfer loads row, buffer outputs
// - Write transfer copies buffer into row
// - Write transfer directly after read accepted
// - Write destination is captured row address
// - Tap start from column strobe address
// - After write transfer, lines are inputs
// - Pseudo write switches to input, moves no data
// - Pseudo write: mask low, gate high
// - Pseudo write column sets write tap
// - Tap advances per shift clock, wraps
// - Power-up: input mode, mask enabled, tap invalid
module vdrt_xfer_ctrl
  import vdrt_pkg::*;
(
  // System
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Link clock
  input  wire logic                 shiftClock,
  // Strobes from controller, active low
  input  wire logic                 rowStrobeN,
  input  wire logic                 colStrobeN,
  input  wire logic                 transferSelectOutputEnableN,
  input  wire logic                 writeMaskWriteEnableN,
  input  wire logic                 shiftPortGateN,
  input  wire logic [ROW_W-1:0]     addr,
  // Array transfer request
  output logic                      arrayReadReq,
  output logic                      arrayWriteReq,
  output logic [ROW_W-1:0]          arrayRow,
  // Buffer status
  output vdrt_pkg::vdrt_mode_e      shiftDataLinesMode,
  output logic                      shiftDataLinesOe,
  output logic                      shiftSerialWriteEn,
  output logic                      maskRegisterWriteEn,
  output vdrt_pkg::vdrt_xfer_e      xferType,
  output logic [COL_W-1:0]          tapPtr,
  output logic                      tapValid
);
  import vdrt_pkg::*;

  // Pin synchronisers
  logic [1:0] rasS_q, casS_q, dtS_q, weS_q, gateS_q;
  logic [ROW_W-1:0] addrS1_q, addrS2_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rasS_q   <= 2'h3;
      casS_q   <= 2'h3;
      dtS_q    <= 2'h3;
      weS_q    <= 2'h3;
      gateS_q  <= 2'h3;
      addrS1_q <= '0;
      addrS2_q <= '0;
    end else begin
      rasS_q   <= {rasS_q[0], rowStrobeN};
      casS_q   <= {casS_q[0], colStrobeN};
      dtS_q    <= {dtS_q[0], transferSelectOutputEnableN};
      weS_q    <= {weS_q[0], writeMaskWriteEnableN};
      gateS_q  <= {gateS_q[0], shiftPortGateN};
      addrS1_q <= addr;
      addrS2_q <= addrS1_q;
    end
  end

  logic ras, cas, dt, we, gate;
  assign ras = rasS_q[1];
  assign cas = casS_q[1];
  assign dt  = dtS_q[1];
  assign we  = weS_q[1];
  assign gate = gateS_q[1];

  logic rasPrev_q, casPrev_q, dtPrev_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rasPrev_q <= 1'b1;
      casPrev_q <= 1'b1;
      dtPrev_q  <= 1'b1;
    end else begin
      rasPrev_q <= ras;
      casPrev_q <= cas;
      dtPrev_q  <= dt;
    end
  end

  logic rasFall, rasRise, casFall, dtRise;
  assign rasFall = rasPrev_q & ~ras;
  assign rasRise = ~rasPrev_q & ras;
  assign casFall = casPrev_q & ~cas;
  assign dtRise  = ~dtPrev_q & dt;

  // Decode at row strobe fall
  vdrt_xfer_e decode;
  always_comb begin
    decode = VDRT_XFER_NONE;
    if (!dt && cas) begin
      if (we) begin
        decode = VDRT_XFER_READ;
      end else if (!gate) begin
        decode = VDRT_XFER_WRITE;
      end else begin
        decode = VDRT_XFER_PSEUDO;
      end
    end
  end

  typedef enum {ST_IDLE, ST_ROW, ST_DONE} vdrt_state_e;
  vdrt_state_e state_q;
  vdrt_xfer_e  type_q;
  logic [ROW_W-1:0] row_q;
  logic [COL_W-1:0] col_q;
  logic             colSeen_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      type_q    <= VDRT_XFER_NONE;
      row_q     <= '0;
      col_q     <= '0;
      colSeen_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          colSeen_q <= 1'b0;
          if (rasFall && decode != VDRT_XFER_NONE) begin
            type_q  <= decode;
            row_q   <= addrS2_q;
            state_q <= ST_ROW;
          end
        end
        ST_ROW: begin
          if (casFall && !colSeen_q) begin
            col_q     <= COL_W'(addrS2_q);
            colSeen_q <= 1'b1;
          end
          if (type_q == VDRT_XFER_READ ? dtRise : rasRise) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          type_q  <= VDRT_XFER_NONE;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic finish;
  assign finish = (state_q == ST_DONE);

  // One-cycle array requests; pseudo write moves no data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arrayReadReq  <= 1'b0;
      arrayWriteReq <= 1'b0;
      arrayRow      <= '0;
    end else begin
      arrayReadReq  <= finish && type_q == VDRT_XFER_READ;
      arrayWriteReq <= finish && type_q == VDRT_XFER_WRITE;
      if (finish) begin
        arrayRow <= row_q;
      end
    end
  end

  // Buffer mode; power-up state is input with mask enabled
  vdrt_mode_e mode_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q              <= VDRT_MODE_INPUT;
      maskRegisterWriteEn <= 1'b1;
    end else if (finish) begin
      if (type_q == VDRT_XFER_READ) begin
        mode_q <= VDRT_MODE_OUTPUT;
      end else begin
        mode_q <= VDRT_MODE_INPUT;
      end
    end
  end
  assign shiftDataLinesMode = mode_q;
  assign shiftDataLinesOe   = (mode_q == VDRT_MODE_OUTPUT) && !gate;
  assign shiftSerialWriteEn = (mode_q == VDRT_MODE_INPUT) && !gate
                              && state_q == ST_IDLE;
  assign xferType = type_q;

  // Tap load crosses to shift clock domain by toggle
  logic tgl_q;
  logic [COL_W-1:0] loadCol_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tgl_q     <= 1'b0;
      loadCol_q <= '0;
    end else if (finish && colSeen_q) begin
      tgl_q     <= ~tgl_q;
      loadCol_q <= col_q;
    end
  end

  vdrt_tap_if tapIf ();
  assign tapIf.loadTgl = tgl_q;
  assign tapIf.loadCol = loadCol_q;

  vdrt_tap_ptr uTap (
    .shiftClock (shiftClock),
    .rstn       (rstn),
    .tapIf      (tapIf)
  );

  // Pointer arrives gray coded; a load jump may show one torn view
  logic [2:0]       vS_q;
  logic [COL_W-1:0] ptrS1_q, ptrS2_q, ptrBin_q;
  logic [COL_W-1:0] ptrBin;
  for (genvar b = 0; b < COL_W; b++) begin : gGray
    assign ptrBin[b] = ^ptrS2_q[COL_W-1:b];
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vS_q     <= 3'h0;
      ptrS1_q  <= '0;
      ptrS2_q  <= '0;
      ptrBin_q <= '0;
    end else begin
      vS_q     <= {vS_q[1:0], tapIf.tapValid};
      ptrS1_q  <= tapIf.tapPtr;
      ptrS2_q  <= ptrS1_q;
      ptrBin_q <= ptrBin;
    end
  end
  assign tapValid = vS_q[2];
  assign tapPtr   = ptrBin_q;
endmodule : vdrt_xfer_ctrl

// ==== dv/vdrt_xfer_monitor.sv ====
`timescale 1ns/10ps
module vdrt_xfer_monitor
  import vdrt_pkg::*;
(
  // Observed ports
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             rowStrobeN,
  input wire logic             transferSelectOutputEnableN,
  input wire logic [ROW_W-1:0] addr,
  input wire logic             arrayReadReq,
  input wire logic             arrayWriteReq,
  input wire logic [ROW_W-1:0] arrayRow,
  input wire vdrt_mode_e       shiftDataLinesMode,
  input wire logic             maskRegisterWriteEn,
  input wire vdrt_xfer_e       xferType,
  input wire logic             tapValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Row on the pins at each row strobe fall
  logic             rowPrev_q;
  logic [ROW_W-1:0] rowSeen_q;
  always_ff @(posedge clk_sys) begin
    rowPrev_q <= rowStrobeN;
    if (rowPrev_q && !rowStrobeN) begin
      rowSeen_q <= addr;
    end
  end
  sequence s_wr; arrayWriteReq; endsequence
  sequence s_rd; arrayReadReq; endsequence
  sequence s_wr_end;
    $rose(rowStrobeN) && xferType == VDRT_XFER_WRITE;
  endsequence
  sequence s_rd_end;
    $rose(transferSelectOutputEnableN) && xferType == VDRT_XFER_READ;
  endsequence
  sequence s_ps_end;
    $rose(rowStrobeN) && xferType == VDRT_XFER_PSEUDO;
  endsequence
  property p_wr_in; s_wr |-> shiftDataLinesMode == VDRT_MODE_INPUT; endproperty
  a_wr_in: assert property (p_wr_in) else $error("write mode");
  property p_rd_out; s_rd |-> shiftDataLinesMode == VDRT_MODE_OUTPUT;
  endproperty
  a_rd_out: assert property (p_rd_out) else $error("read mode");
  property p_pulse; s_wr |=> !arrayWriteReq; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse");
  property p_row;
    arrayWriteReq || arrayReadReq |-> arrayRow == rowSeen_q;
  endproperty
  a_row: assert property (p_row) else $error("row moved");
  property p_wr_end; s_wr_end |-> ##[1:8] s_wr; endproperty
  a_wr_end: assert property (p_wr_end) else $error("no write");
  property p_rd_end; s_rd_end |-> ##[1:8] s_rd; endproperty
  a_rd_end: assert property (p_rd_end) else $error("no read");
  property p_ps; s_ps_end |-> ##1 (!arrayWriteReq) [*8]; endproperty
  a_ps: assert property (p_ps) else $error("pseudo wrote");
  property p_ps_mode;
    s_ps_end |-> ##4 shiftDataLinesMode == VDRT_MODE_INPUT;
  endproperty
  a_ps_mode: assert property (p_ps_mode) else $error("pseudo mode");
  property p_rst; $rose(rstn) |-> maskRegisterWriteEn && !tapValid &&
    shiftDataLinesMode == VDRT_MODE_INPUT; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule : vdrt_xfer_monitor
bind vdrt_xfer_ctrl vdrt_xfer_monitor u_mon (.clk_sys, .rstn, .rowStrobeN,
  .transferSelectOutputEnableN, .addr, .arrayReadReq, .arrayWriteReq,
  .arrayRow, .shiftDataLinesMode, .maskRegisterWriteEn, .xferType, .tapValid);

// ==== dv/vdrt_host_model.sv ====
`timescale 1ns/10ps
module vdrt_host_model
  import vdrt_pkg::*;
(
  // Clock in, pins out
  input  wire logic        clk_sys,
  output logic             shiftClock,
  output logic             rowStrobeN,
  output logic             colStrobeN,
  output logic             transferSelectOutputEnableN,
  output logic             writeMaskWriteEnableN,
  output logic             shiftPortGateN,
  output logic [ROW_W-1:0] addr
);
  initial begin
    {rowStrobeN, colStrobeN, transferSelectOutputEnableN} = 3'h7;
    {writeMaskWriteEnableN, shiftPortGateN, shiftClock} = 3'h6;
    addr = 9'h000;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : gap
  task automatic shift(input int n);
    repeat (n) begin
      #6 shiftClock = 1'b1;
      #6 shiftClock = 1'b0;
    end
  endtask : shift
  task automatic init;
    gap(20000);
    repeat (8) begin
      rowStrobeN = 1'b0;
      gap(6);
      rowStrobeN = 1'b1;
      gap(6);
    end
    shift(8);
  endtask : init
  // Shift clock held still for the whole row cycle
  task automatic xfer(input logic s, m, g, input logic [8:0] row, col);
    gap(1);
    {transferSelectOutputEnableN, writeMaskWriteEnableN, shiftPortGateN}
      = {s, m, g};
    addr = row;
    gap(2);
    rowStrobeN = 1'b0;
    gap(6);
    addr = col;
    gap(2);
    colStrobeN = 1'b0;
    gap(6);
    addr = ~col;
    if (m) transferSelectOutputEnableN = 1'b1;
    gap(6);
    {rowStrobeN, colStrobeN, transferSelectOutputEnableN} = 3'h7;
    gap(10);
  endtask : xfer
endmodule : vdrt_host_model

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import vdrt_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rstn = 1'b0;
  logic             shiftClock, rowStrobeN, colStrobeN, shiftPortGateN;
  logic             transferSelectOutputEnableN, writeMaskWriteEnableN;
  logic             arrayReadReq, arrayWriteReq, shiftDataLinesOe;
  logic             shiftSerialWriteEn, maskRegisterWriteEn, tapValid;
  logic [ROW_W-1:0] addr, arrayRow;
  logic [COL_W-1:0] tapPtr, p0;
  vdrt_mode_e       shiftDataLinesMode;
  vdrt_xfer_e       xferType;
  int               error_cnt = 0;
  int               num_checks = 0;
  int               rdCnt = 0;
  int               wrCnt = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (arrayReadReq === 1'b1) rdCnt <= rdCnt + 1;
    if (arrayWriteReq === 1'b1) wrCnt <= wrCnt + 1;
  end
  vdrt_host_model u_vdrt_host_model (.clk_sys, .shiftClock, .rowStrobeN,
    .colStrobeN, .transferSelectOutputEnableN, .writeMaskWriteEnableN,
    .shiftPortGateN, .addr);
  vdrt_xfer_ctrl u_vdrt_xfer_ctrl (.clk_sys, .rstn, .shiftClock,
    .rowStrobeN, .colStrobeN, .transferSelectOutputEnableN,
    .writeMaskWriteEnableN, .shiftPortGateN, .addr, .arrayReadReq,
    .arrayWriteReq, .arrayRow, .shiftDataLinesMode, .shiftDataLinesOe,
    .shiftSerialWriteEn, .maskRegisterWriteEn, .xferType, .tapPtr, .tapValid);
  task automatic check(input string what, input logic [9:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Pointer lands near col once loaded, then counts
  task automatic tap_near(input logic [8:0] col);
    u_vdrt_host_model.shift(4);
    u_vdrt_host_model.gap(4);
    p0 = tapPtr - col;
    check("tap", {p0 <= 9'h004, tapValid}, 2'h3);
    p0 = tapPtr;
  endtask : tap_near
  task automatic t_reset;
    check("mask", maskRegisterWriteEn, 1'b1);
    check("mode", shiftDataLinesMode, VDRT_MODE_INPUT);
    check("valid", tapValid, 1'b0);
    u_vdrt_host_model.xfer(1, 0, 0, 9'h005, 9'h005);
    check("refused", rdCnt + wrCnt, 0);
    check("type", xferType, VDRT_XFER_NONE);
  endtask : t_reset
  task automatic t_read(input logic [8:0] row, col, input int n);
    u_vdrt_host_model.xfer(0, 1, 0, row, col);
    check("rd", rdCnt, n);
    check("row", arrayRow, row);
    check("oe", {shiftDataLinesMode, shiftDataLinesOe}, 2'h3);
    check("swe", shiftSerialWriteEn, 1'b0);
    tap_near(col);
    u_vdrt_host_model.shift(8);
    u_vdrt_host_model.gap(4);
    check("wrap", tapPtr, 9'(p0 + 9'h008));
  endtask : t_read
  task automatic t_write(input logic [8:0] row, input int n);
    u_vdrt_host_model.xfer(0, 0, 0, row, 9'h010);
    check("wr", wrCnt, n);
    check("row", arrayRow, row);
    check("mode", shiftDataLinesMode, VDRT_MODE_INPUT);
    check("swe", shiftSerialWriteEn, 1'b1);
  endtask : t_write
  task automatic t_pseudo;
    u_vdrt_host_model.xfer(0, 0, 1, 9'h055, 9'h123);
    check("ps", wrCnt, 0);
    check("mode", shiftDataLinesMode, VDRT_MODE_INPUT);
    check("swe", shiftSerialWriteEn, 1'b0);
    tap_near(9'h123);
  endtask : t_pseudo
  initial begin
    #300000;
    error_cnt++;
    final_report();
  end
  initial begin
    fork
      u_vdrt_host_model.shift(3);
      repeat (8) @(negedge clk_sys);
    join
    rstn = 1'b1;
    u_vdrt_host_model.init();
    t_reset();
    t_read(9'h1A5, 9'h1FC, 1);
    t_pseudo();
    t_write(9'h0AA, 1);
    t_write(9'h155, 2);
    t_read(9'h0F0, 9'h000, 2);
    t_write(9'h0C3, 3);
    final_report();
  end
endmodule : tb
